//--- hdl/dsl_pkg.sv
// Constants shared by the drive status indicator block.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
package dsl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // Control register fields
  localparam int CTRL_CAN_BIT = 0;
  localparam int CTRL_INIT_DONE_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status register fields
  localparam int ST_MERR_LSB = 0;
  localparam int MERR_W = 8;
  localparam int MERR_INVALID_SETUP_BIT = 2;
  localparam int ST_AL_ERR_BIT = 8;
  localparam int ST_DEFAULTS_BIT = 9;
  localparam int ST_STATE_LSB = 10;
  localparam int ST_LINK_LSB = 12;

  // Interrupt status and mask fields
  localparam int IRQ_SETUP_BIT = 0;
  localparam int IRQ_AL_ERR_BIT = 1;
  localparam int IRQ_LINK_BIT = 2;
  localparam int IRQ_CORRUPT_BIT = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_TIME_MS = 50;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYCLES = 4;
  // Pattern lengths in 50 ms ticks
  localparam int BLINK_PERIOD = 8;
  localparam int FLASH_ON = 4;
  localparam int SFLASH_PERIOD = 24;
  localparam int DFLASH_PERIOD = 32;
  localparam int DFLASH_GAP = 8;
  localparam int PAT_FRAME = 96;
  localparam int RUN_PHASE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {
    SS_INIT = 2'h0,
    SS_PREOP = 2'h1,
    SS_SAFEOP = 2'h2,
    SS_OP = 2'h3
  } dsl_slave_type;

  typedef enum logic [1:0] {
    BS_SETTLE = 2'h0,
    BS_SAMPLE = 2'h1,
    BS_RUN = 2'h3
  } dsl_boot_type;

endpackage

//--- hdl/dsl_pat_if.sv
// Carries the time base tick and the generated indicator patterns.
// Assumes one driver of tick and one pattern generator per instance.
`timescale 1ns/1ps
`default_nettype none
interface dsl_pat_if;
  logic tick;
  logic flicker;
  logic blink;
  logic sflash;
  logic dflash;
  modport drv (output tick, input flicker, blink, sflash, dflash);
  modport gen (input tick, output flicker, blink, sflash, dflash);
endinterface
`default_nettype wire

//--- hdl/dsl_pattern_gen.sv
// Indicator pattern generator stepped by the shared 50 ms tick.
// Assumes tick is a single-cycle pulse on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dsl_pattern_gen
  import dsl_pkg::*;
#(
  parameter int PHASE = 0
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Patterns
  dsl_pat_if.gen pat
);

  typedef struct packed {
    logic [6:0] cnt;
    logic flicker;
    logic blink;
    logic sflash;
    logic dflash;
  } dsl_gen_type;

  dsl_gen_type s;
  dsl_gen_type next_s;

  // Reset values are what the counter at PHASE decodes to, so the run and
  // error blink outputs are already in antiphase at the first enabled edge
  localparam logic RST_FLICKER = (PHASE % 2) != 0;
  localparam logic RST_BLINK = (PHASE % BLINK_PERIOD) < (BLINK_PERIOD / 2);
  localparam logic RST_SFLASH = (PHASE % SFLASH_PERIOD) < FLASH_ON;
  localparam int DPH = PHASE % DFLASH_PERIOD;
  localparam logic RST_DFLASH = (DPH < FLASH_ON) ||
    ((DPH >= DFLASH_GAP) && (DPH < DFLASH_GAP + FLASH_ON));

  function automatic logic in_win(logic [6:0] c, int per, int lo, int hi);
    int m;
    m = int'(c) % per;
    return (m >= lo) && (m < hi);
  endfunction

  always_comb
  begin
    next_s = s;
    if (pat.tick)
    begin
      next_s.cnt = (s.cnt == 7'(PAT_FRAME - 1)) ? 7'h00 : s.cnt + 7'h01;
    end
    next_s.flicker = next_s.cnt[0];
    next_s.blink = in_win(next_s.cnt, BLINK_PERIOD, 0, BLINK_PERIOD / 2);
    next_s.sflash = in_win(next_s.cnt, SFLASH_PERIOD, 0, FLASH_ON);
    next_s.dflash = in_win(next_s.cnt, DFLASH_PERIOD, 0, FLASH_ON) ||
      in_win(next_s.cnt, DFLASH_PERIOD, DFLASH_GAP, DFLASH_GAP + FLASH_ON);
  end

  // Phase offset only moves the start point, so both generators stay locked
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '{cnt: 7'(PHASE), flicker: RST_FLICKER, blink: RST_BLINK,
        sflash: RST_SFLASH, dflash: RST_DFLASH};
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  assign pat.flicker = s.flicker;
  assign pat.blink = s.blink;
  assign pat.sflash = s.sflash;
  assign pat.dflash = s.dflash;

endmodule
`default_nettype wire

//--- hdl/dsl_status_led.sv
// Drive status indicators: setup recovery strap, application LEDs,
// fieldbus run/error LEDs, link LEDs, APB registers and interrupt.
// Assumes drive state inputs are on ref_clk; pins are asynchronous.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dsl_status_led
  import dsl_pkg::*;
#(
  parameter int N_HALL = 3,
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive state
  input wire logic [1:0] slave_state,
  input wire logic setup_corrupt,
  input wire logic app_fault,
  input wire logic comm_fail,
  input wire logic wdog_timeout,
  input wire logic local_error,
  input wire logic config_error,
  input wire logic boot_error,
  // Pins
  input wire logic [N_HALL-1:0] hall_in,
  input wire logic [1:0] link_up_in,
  input wire logic [1:0] link_act_in,
  // Drive state outputs
  output logic use_defaults,
  output logic [1:0] eff_slave_state,
  output logic irq,
  // Indicators
  output logic app_ready_led,
  output logic app_error_led,
  output logic bus_run_led,
  output logic bus_error_led,
  output logic port_in_link_led,
  output logic port_out_link_led
);

  localparam int NP = N_HALL + 4;
  localparam int TW = $clog2(TICK_CYCLES_P);

  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] s3;
    logic [NP-1:0] filt;
    dsl_boot_type boot;
    logic [2:0] settle;
    logic [TW-1:0] tick_cnt;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [MERR_W-1:0] merr;
    logic al_error;
    logic use_defaults;
    logic [1:0] eff_state;
    logic prev_al;
    logic prev_corrupt;
    logic [31:0] prdata;
    logic ready_led;
    logic error_led;
    logic run_led;
    logic berr_led;
    logic [1:0] link_led;
  } dsl_state_type;

  dsl_state_type s;
  dsl_state_type next_s;

  dsl_pat_if err_pat ();
  dsl_pat_if run_pat ();

  logic [N_HALL-1:0] hall_f;
  logic [1:0] up_f;
  logic [1:0] act_f;
  logic tick;
  logic acc;
  logic wr;
  logic any_err;
  logic can_mode;

  function automatic logic ofs_ok(logic [7:0] a);
    return (a == CTRL_OFS) || (a == STATUS_OFS) ||
      (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction

  function automatic logic wr_hit(logic w, logic [7:0] a, logic [7:0] o);
    return w && (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generators; the run side starts a half blink period ahead

  dsl_pattern_gen #(.PHASE(0)) u_err_gen (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .pat(err_pat.gen)
  );

  dsl_pattern_gen #(.PHASE(RUN_PHASE)) u_run_gen (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .pat(run_pat.gen)
  );

  assign tick = (s.tick_cnt == TW'(TICK_CYCLES_P - 1));
  assign err_pat.tick = tick;
  assign run_pat.tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  assign hall_f = s.filt[N_HALL-1:0];
  assign up_f = s.filt[N_HALL+1:N_HALL];
  assign act_f = s.filt[N_HALL+3:N_HALL+2];
  assign can_mode = s.ctrl[CTRL_CAN_BIT];
  assign acc = psel && penable;
  assign wr = acc && pwrite && ofs_ok(paddr);
  assign any_err = app_fault || comm_fail || wdog_timeout || local_error ||
    config_error || boot_error || (s.merr != '0);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic al_set;
    ev = '0;
    clr = '0;
    al_set = local_error || boot_error;
    next_s = s;

    // Pins: a change counts once the second and third stages agree
    next_s.s1 = {link_act_in, link_up_in, hall_in};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.filt = (s.s2 & ~(s.s2 ^ s.s3)) | (s.filt & (s.s2 ^ s.s3));

    next_s.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);

    // Strap capture, once after release of reset
    case (s.boot)
      BS_SETTLE:
      begin
        next_s.settle = s.settle + 3'h1;
        if (s.settle == 3'(SETTLE_CYCLES - 1))
        begin
          next_s.boot = BS_SAMPLE;
        end
      end
      BS_SAMPLE:
      begin
        if (hall_f == '0)
        begin
          next_s.use_defaults = 1'b1;
          next_s.merr[MERR_INVALID_SETUP_BIT] = 1'b1;
          ev[IRQ_SETUP_BIT] = 1'b1;
        end
        next_s.boot = BS_RUN;
      end
      BS_RUN:
      begin
        next_s.boot = BS_RUN;
      end
      default:
      begin
        next_s.boot = BS_SETTLE;
      end
    endcase

    next_s.eff_state = boot_error ? SS_INIT : slave_state;

    ev[IRQ_AL_ERR_BIT] = al_set && !s.prev_al;
    ev[IRQ_LINK_BIT] = (up_f != next_s.filt[N_HALL+1:N_HALL]);
    ev[IRQ_CORRUPT_BIT] = setup_corrupt && !s.prev_corrupt;
    next_s.prev_al = al_set;
    next_s.prev_corrupt = setup_corrupt;

    // APB: read data is latched in the setup cycle, writes land on access
    if (psel && !penable)
    begin
      case (paddr)
        CTRL_OFS: next_s.prdata = 32'(s.ctrl);
        STATUS_OFS:
        begin
          next_s.prdata = '0;
          next_s.prdata[ST_MERR_LSB +: MERR_W] = s.merr;
          next_s.prdata[ST_AL_ERR_BIT] = s.al_error;
          next_s.prdata[ST_DEFAULTS_BIT] = s.use_defaults;
          next_s.prdata[ST_STATE_LSB +: 2] = s.eff_state;
          next_s.prdata[ST_LINK_LSB +: 2] = up_f;
        end
        IRQ_STAT_OFS: next_s.prdata = 32'(s.irq_stat);
        IRQ_MASK_OFS: next_s.prdata = 32'(s.irq_mask);
        default: next_s.prdata = '0;
      endcase
    end
    if (wr_hit(wr, paddr, CTRL_OFS))
    begin
      next_s.ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_hit(wr, paddr, IRQ_MASK_OFS))
    begin
      next_s.irq_mask = pwdata[IRQ_W-1:0];
    end
    if (wr_hit(wr, paddr, IRQ_STAT_OFS))
    begin
      clr = pwdata[IRQ_W-1:0];
    end
    // Set wins over a same-cycle write-one-to-clear
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;

    // AL error bit on local or booting error
    next_s.al_error = al_set ||
      (s.al_error && !(wr_hit(wr, paddr, STATUS_OFS) &&
      pwdata[ST_AL_ERR_BIT]));

    // Application LEDs
    if (setup_corrupt)
    begin
      next_s.ready_led = err_pat.flicker;
      next_s.error_led = !err_pat.flicker;
    end
    else
    begin
      next_s.error_led = any_err;
      // ready after init, off on error
      next_s.ready_led = s.ctrl[CTRL_INIT_DONE_BIT] &&
        (s.boot == BS_RUN) && !any_err;
    end

    case (next_s.eff_state)
      SS_INIT: next_s.run_led = 1'b0;
      SS_PREOP: next_s.run_led = run_pat.blink;
      SS_SAFEOP: next_s.run_led = run_pat.sflash;
      SS_OP: next_s.run_led = 1'b1;
      default: next_s.run_led = 1'b0;
    endcase

    // Bus error LED, most severe class first
    if (comm_fail || app_fault)
    begin
      next_s.berr_led = 1'b1;
    end
    else if (wdog_timeout)
    begin
      next_s.berr_led = err_pat.dflash;
    end
    else if (local_error)
    begin
      next_s.berr_led = err_pat.sflash;
    end
    else if (config_error)
    begin
      next_s.berr_led = err_pat.blink;
    end
    else if (boot_error)
    begin
      next_s.berr_led = err_pat.flicker;
    end
    else
    begin
      next_s.berr_led = 1'b0;
    end

    // link up lit, traffic flickers it
    next_s.link_led = up_f & ~(act_f & {2{err_pat.flicker}});

    // CAN variant keeps bus LEDs dark
    if (can_mode)
    begin
      next_s.run_led = 1'b0;
      next_s.berr_led = 1'b0;
      next_s.link_led = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; ce low freezes everything, the APB port included

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '{boot: BS_SETTLE, ctrl: CTRL_RST, irq_stat: IRQ_RST,
        irq_mask: IRQ_RST, eff_state: SS_INIT, default: '0};
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = ce;
  assign pslverr = acc && !ofs_ok(paddr);
  assign use_defaults = s.use_defaults;
  assign eff_slave_state = s.eff_state;
  assign irq = |(s.irq_stat & s.irq_mask);
  assign app_ready_led = s.ready_led;
  assign app_error_led = s.error_led;
  assign bus_run_led = s.run_led;
  assign bus_error_led = s.berr_led;
  assign port_in_link_led = s.link_led[0];
  assign port_out_link_led = s.link_led[1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence strap_seen_s;
    ce && (s.boot == BS_SAMPLE) && (hall_f == '0);
  endsequence

  sequence defaults_up_s;
    use_defaults && s.merr[MERR_INVALID_SETUP_BIT] ##1
      (ce && (s.boot == BS_RUN));
  endsequence

  corrupt_alternate_a: assert property (
    ce && setup_corrupt |=> app_ready_led != app_error_led)
    else $error("ready and error LEDs not alternating");

  strap_defaults_a: assert property (
    strap_seen_s |=> defaults_up_s)
    else $error("strap did not load defaults");

  app_error_on_a: assert property (
    ce && any_err && !setup_corrupt |=> app_error_led)
    else $error("error LED dark during error");

  ready_off_a: assert property (
    ce && any_err |=> !app_ready_led || $past(setup_corrupt))
    else $error("ready LED lit during error");

  can_dark_a: assert property (
    ce && can_mode |=> !bus_run_led && !bus_error_led &&
      !port_in_link_led && !port_out_link_led)
    else $error("bus LED lit in CAN variant");

  run_antiphase_a: assert property (
    run_pat.blink != err_pat.blink)
    else $error("run and error blink in phase");

  run_op_on_a: assert property (
    ce && !can_mode && !boot_error && (slave_state == SS_OP)
      |=> bus_run_led)
    else $error("run LED dark in operational");

  fail_steady_a: assert property (
    (ce && !can_mode && comm_fail) [*2] |=>
      bus_error_led && $past(bus_error_led))
    else $error("error LED not steady on failure");

  al_error_set_a: assert property (
    ce && (local_error || boot_error) |=> s.al_error)
    else $error("AL error bit not set");

  boot_init_a: assert property (
    ce && boot_error |=> eff_slave_state == SS_INIT)
    else $error("booting error left init");

  healthy_off_a: assert property (
    ce && !comm_fail && !app_fault && !wdog_timeout && !local_error &&
      !config_error && !boot_error |=> !bus_error_led)
    else $error("bus error LED lit while healthy");

  link_down_a: assert property (
    ce && (up_f == 2'h0) |=> !port_in_link_led && !port_out_link_led)
    else $error("link LED lit without link");

endmodule
`default_nettype wire

//--- verif/dsl_led_operator.sv
// Operator watching the indicators, and the Hall strap wiring.
// Assumes indicators are registered on ref_clk; counts cover one window.
`timescale 1ns/1ps
`default_nettype none
module dsl_led_operator
(
  // Clock and window control
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic en,
  input wire logic strap,
  // Indicators: ready, app error, run, bus error, in link, out link
  input wire logic [5:0] leds,
  // Hall pins and observations
  output logic [2:0] hall_in,
  output int lit [6],
  output int bus_split,
  output int app_split
);
  assign hall_in = strap ? 3'h0 : 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // An unknown LED is never counted as lit
  always @(posedge ref_clk)
  begin
    if (clr)
    begin
      for (int i = 0; i < 6; i++)
        lit[i] <= 0;
      bus_split <= 0;
      app_split <= 0;
    end
    else if (en)
    begin
      for (int i = 0; i < 6; i++)
        lit[i] <= lit[i] + int'(leds[i] === 1'b1);
      bus_split <= bus_split + int'((leds[2] ^ leds[3]) === 1'b1);
      app_split <= app_split + int'((leds[0] ^ leds[1]) === 1'b1);
    end
  end
endmodule
`default_nettype wire

//--- verif/drive_status_led_indicator_bench.sv
// Self-checking bench for the drive status indicator block.
// Assumes a 4-cycle pattern tick so one pattern frame is 384 cycles.
`timescale 1ns/1ps
`default_nettype none
module drive_status_led_indicator_bench;
  import dsl_pkg::*;
  localparam int TK = 4;
  localparam int FRAME = PAT_FRAME * TK;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] slave_state = 2'h0;
  logic setup_corrupt = 0;
  logic [5:0] errv = 6'h0;
  logic [1:0] link_up_in = 2'h0;
  logic [1:0] link_act_in = 2'h0;
  logic use_defaults;
  logic [1:0] eff_slave_state;
  logic irq;
  logic [5:0] leds;
  logic [2:0] hall_in;
  logic clr = 0;
  logic en = 0;
  logic strap = 0;
  logic [31:0] rd;
  logic [31:0] rnd;
  logic er;
  int lit [6];
  int bus_split;
  int app_split;
  int fail_count = 0;
  int compares = 0;
  int exp_run [4];
  int exp_err [6];

  always #5 ref_clk = ~ref_clk;

  dsl_status_led #(.TICK_CYCLES_P(TK)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slave_state(slave_state), .setup_corrupt(setup_corrupt),
    .app_fault(errv[0]), .comm_fail(errv[1]), .wdog_timeout(errv[2]),
    .local_error(errv[3]), .config_error(errv[4]), .boot_error(errv[5]),
    .hall_in(hall_in), .link_up_in(link_up_in), .link_act_in(link_act_in),
    .use_defaults(use_defaults), .eff_slave_state(eff_slave_state),
    .irq(irq), .app_ready_led(leds[0]), .app_error_led(leds[1]),
    .bus_run_led(leds[2]), .bus_error_led(leds[3]),
    .port_in_link_led(leds[4]), .port_out_link_led(leds[5]));

  dsl_led_operator op (
    .ref_clk(ref_clk), .clr(clr), .en(en), .strap(strap), .leds(leds),
    .hall_in(hall_in), .lit(lit), .bus_split(bus_split),
    .app_split(app_split));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask

  // Master holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic s);
    strap <= s;
    arst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
  endtask

  // One whole frame, so every pattern shows its full duty
  task automatic window();
    repeat (12) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    en <= 1'b1;
    repeat (FRAME) @(posedge ref_clk);
    en <= 1'b0;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    exp_run = '{0, FRAME / 2, FRAME * FLASH_ON / SFLASH_PERIOD, FRAME};
    exp_err = '{FRAME, FRAME, FRAME * 2 * FLASH_ON / DFLASH_PERIOD,
                FRAME * FLASH_ON / SFLASH_PERIOD, FRAME / 2, FRAME / 2};
    void'($urandom(17845));
    do_reset(1'b1);
    check({31'h0, use_defaults}, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(32'(rd[MERR_INVALID_SETUP_BIT]), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h2);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    check(rd, 32'h1);
    check({30'h0, irq, leds[1]}, 32'h3);
    check({31'h0, leds[0]}, 32'h0);
    apb(1'b1, IRQ_STAT_OFS, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    check({31'h0, irq}, 32'h0);
    $display("test strap done");
    do_reset(1'b0);
    apb(1'b0, CTRL_OFS, 32'h0);
    check({rd[31:1], use_defaults}, 32'h0);
    rnd = $urandom;
    apb(1'b1, IRQ_MASK_OFS, rnd);
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    check(rd, rnd & 32'((1 << IRQ_W) - 1));
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    apb(1'b1, CTRL_OFS, 32'h2);
    repeat (4) @(posedge ref_clk);
    check({30'h0, leds[1:0]}, 32'h1);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      slave_state <= 2'(s);
      window();
      check(32'(lit[2]), 32'(exp_run[s]));
    end
    $display("test run led done");
    for (int k = 0; k < 6; k++)
    begin
      errv <= 6'(1 << k);
      repeat (2) @(posedge ref_clk);
      apb(1'b1, STATUS_OFS, 32'h100);
      window();
      check(32'(lit[3]), 32'(exp_err[k]));
      apb(1'b0, STATUS_OFS, 32'h0);
      check(32'(rd[ST_AL_ERR_BIT]), 32'(k == 3 || k == 5));
      if (k == 3)
        check({31'h0, irq}, 32'h1);
      if (k == 5)
        check({eff_slave_state, 30'(lit[2])}, 32'h0);
      apb(1'b1, IRQ_STAT_OFS, 32'hf);
    end
    errv <= 6'h0;
    window();
    check(32'(lit[3]), 32'h0);
    $display("test error led done");
    slave_state <= SS_PREOP;
    errv <= 6'h10;
    window();
    check(32'(bus_split), 32'(FRAME));
    // Enable low must freeze the blinking LEDs and stretch the bus
    ce <= 1'b0;
    @(posedge ref_clk);
    rd = {26'h0, leds};
    repeat (40) @(posedge ref_clk);
    check({26'h0, leds}, rd);
    check({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    errv <= 6'h0;
    setup_corrupt <= 1'b1;
    window();
    check({32'(app_split)}, 32'(FRAME));
    check(32'(lit[0]), 32'(FRAME / 2));
    setup_corrupt <= 1'b0;
    link_up_in <= 2'h3;
    link_act_in <= 2'h1;
    window();
    check(32'(lit[4] + 2 * lit[5]), 32'(FRAME / 2 + 2 * FRAME));
    $display("test phase and link done");
    apb(1'b1, CTRL_OFS, 32'h3);
    slave_state <= SS_OP;
    errv <= 6'h2;
    window();
    check(32'(lit[2] + lit[3] + lit[4] + lit[5]), 32'h0);
    $display("test can variant done");
    summarize();
  end
endmodule
`default_nettype wire
